// [mcsd_pkg.sv]
// Purpose: shared constants for the muting configuration switch decoder
// Assumes: 250 MHz system clock
// Notes: register map and field layout live here
package mcsd_pkg;
  localparam int unsigned MCSD_CLK_MHZ = 250;
  localparam int unsigned MCSD_BANK_W = 8;
  // Register byte offsets
  localparam logic [7:0] MCSD_OFF_STATUS = 8'h00;
  localparam logic [7:0] MCSD_OFF_MASK = 8'h04;
  localparam logic [7:0] MCSD_OFF_CONFIG = 8'h08;
  localparam logic [7:0] MCSD_OFF_LIVE = 8'h0c;
  localparam logic [7:0] MCSD_OFF_CTRL = 8'h10;
  // Status bit positions
  localparam int unsigned MCSD_ST_MISMATCH = 0;
  localparam int unsigned MCSD_ST_CHANGE = 1;
  localparam int unsigned MCSD_ST_MODE = 2;
  localparam int unsigned MCSD_ST_READY = 3;
  localparam int unsigned MCSD_ST_W = 4;
  // Switch positions within a bank
  localparam int unsigned MCSD_SW_SENSORS = 0;
  localparam int unsigned MCSD_SW_SEQ = 1;
  localparam int unsigned MCSD_SW_EXT = 2;
  localparam int unsigned MCSD_SW_RESTART = 3;
  localparam int unsigned MCSD_SW_MUTSRC = 4;
  localparam int unsigned MCSD_SW_RSTSRC = 5;
  localparam int unsigned MCSD_SW_TO_HI = 6;
  localparam int unsigned MCSD_SW_TO_LO = 7;
  // Reset values
  localparam logic [MCSD_ST_W-1:0] MCSD_MASK_RST = 4'h0;
  // Settle time after reset before the banks are captured
  localparam int unsigned MCSD_SETTLE_US = 10;
  localparam int unsigned MCSD_SETTLE_CYC = MCSD_SETTLE_US * MCSD_CLK_MHZ;
  // Timeout selections in seconds
  localparam logic [31:0] MCSD_TO_SEC_0 = 32'h0000_0014;
  localparam logic [31:0] MCSD_TO_SEC_1 = 32'h0000_0078;
  localparam logic [31:0] MCSD_TO_SEC_2 = 32'h0000_0258;
  localparam logic [31:0] MCSD_TO_SEC_3 = 32'h0005_7e40;
  // Seven-segment code base
  localparam logic [6:0] MCSD_SEG_BLANK = 7'h00;
  localparam logic [6:0] MCSD_SEG_ERR = 7'h79;
  typedef enum logic [2:0] {
    MCSD_ST_SETTLE = 3'b001,
    MCSD_ST_RUN = 3'b010,
    MCSD_ST_FAULT = 3'b100
  } mcsd_state_type;
endpackage : mcsd_pkg

// [mcsd_switch_model.sv]
// Purpose: behavioural model of the two manually set configuration switch banks
// Assumes: switches are static levels, moved only when the bench commands it
// Notes: skew_i flips bank B positions to model a mis-set second bank
`timescale 1ns/1ps
`default_nettype none
module mcsd_switch_model (
  input wire logic [7:0] setting_i,
  input wire logic [7:0] skew_i,
  output logic [7:0] bank_a_o,
  output logic [7:0] bank_b_o
);
  // Both banks carry the same setting unless a scenario asks for a mis-set bank
  assign bank_a_o = setting_i;
  assign bank_b_o = setting_i ^ skew_i;
endmodule : mcsd_switch_model
`default_nettype wire

// [mcsd_sync.sv]
// Purpose: two-stage synchroniser for a group of switch pins
// Assumes: inputs are slow, asynchronous levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module mcsd_sync #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : mcsd_sync
`default_nettype wire

// [mcsd_top.sv]
// Purpose: capture, compare and decode the two configuration switch banks
// Assumes: switch pins are asynchronous; one 250 MHz clock
// Notes: any fault latches until reset and forces both safety outputs off
`timescale 1ns/1ps
`default_nettype none
module mcsd_top
  import mcsd_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = MCSD_SETTLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [MCSD_BANK_W-1:0] bank_a_i,
  input wire logic [MCSD_BANK_W-1:0] bank_b_i,
  input wire logic safety_enable_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o,
  output logic safety_out_a_o,
  output logic safety_out_b_o,
  output logic fault_o,
  output logic config_valid_o,
  output logic four_sensor_o,
  output logic sequence_mode_o,
  output logic extension_en_o,
  output logic restart_local_o,
  output logic mute_from_first_muting_sensor_o,
  output logic reset_from_control_o,
  output logic [1:0] timeout_sel_o,
  output logic [31:0] timeout_sec_o,
  output logic [6:0] mode_num_o,
  output logic [6:0] seg_tens_o,
  output logic [6:0] seg_ones_o
);
  logic [2*MCSD_BANK_W-1:0] banks_sync;
  logic [MCSD_BANK_W-1:0] live_a;
  logic [MCSD_BANK_W-1:0] live_b;
  logic [MCSD_BANK_W-1:0] captured;
  mcsd_state_type state;
  logic [31:0] settle_cnt;
  logic mismatch_now;
  logic change_now;
  logic mode_bad_now;
  logic [MCSD_ST_W-1:0] status;
  logic [MCSD_ST_W-1:0] mask;
  logic [MCSD_ST_W-1:0] events;
  logic [MCSD_ST_W-1:0] fault_hold;
  logic [6:0] next_mode;
  logic mode_ok;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Switch pins are mechanical and asynchronous to the clock
  mcsd_sync #(
    .WIDTH(2 * MCSD_BANK_W)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({bank_b_i, bank_a_i}),
    .sync_o(banks_sync)
  );
  assign live_a = banks_sync[MCSD_BANK_W-1:0];
  assign live_b = banks_sync[2*MCSD_BANK_W-1:MCSD_BANK_W];

  // Start-up: wait for contacts to settle, capture once, then monitor
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state <= MCSD_ST_SETTLE;
      settle_cnt <= 32'h0000_0000;
      captured <= '0;
    end else begin
      unique case (state)
        MCSD_ST_SETTLE: begin
          if (settle_cnt >= SETTLE_CYC - 1) begin
            captured <= live_a;
            state <= (mismatch_now || !mode_ok) ? MCSD_ST_FAULT : MCSD_ST_RUN;
          end else begin
            settle_cnt <= settle_cnt + 32'h0000_0001;
          end
        end
        MCSD_ST_RUN: begin
          if (mismatch_now || change_now) begin
            state <= MCSD_ST_FAULT;
          end
        end
        MCSD_ST_FAULT: begin
          state <= MCSD_ST_FAULT;
        end
      endcase
    end
  end

  assign mismatch_now = (live_a != live_b);
  assign change_now = (state == MCSD_ST_RUN) &&
                      ((live_a != captured) || (live_b != captured));

  // Operating mode number from switches 1..6; 4-sensor only with sequence mode
  always_comb begin
    next_mode = 7'h00;
    mode_ok = 1'b1;
    if (live_a[MCSD_SW_SENSORS] && !live_a[MCSD_SW_SEQ]) begin
      mode_ok = 1'b0;
    end else begin
      next_mode = {1'b0, live_a[MCSD_SW_SENSORS], live_a[MCSD_SW_SEQ],
                   live_a[MCSD_SW_EXT], live_a[MCSD_SW_RESTART],
                   !live_a[MCSD_SW_MUTSRC], live_a[MCSD_SW_RSTSRC]} + 7'h01;
    end
  end
  assign mode_bad_now = (state == MCSD_ST_SETTLE) && (settle_cnt >= SETTLE_CYC - 1) &&
                        !mode_ok;

  // Decoded settings load from live bank A at the capture edge only, the same edge that fills the captured copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_num_o <= 7'h00;
      four_sensor_o <= 1'b0;
      sequence_mode_o <= 1'b0;
      extension_en_o <= 1'b0;
      restart_local_o <= 1'b0;
      mute_from_first_muting_sensor_o <= 1'b0;
      reset_from_control_o <= 1'b0;
      timeout_sel_o <= 2'h0;
    end else if (state == MCSD_ST_SETTLE && settle_cnt >= SETTLE_CYC - 1) begin
      mode_num_o <= next_mode;
      four_sensor_o <= live_a[MCSD_SW_SENSORS];
      sequence_mode_o <= live_a[MCSD_SW_SEQ];
      extension_en_o <= live_a[MCSD_SW_EXT];
      restart_local_o <= live_a[MCSD_SW_RESTART];
      mute_from_first_muting_sensor_o <= live_a[MCSD_SW_MUTSRC];
      reset_from_control_o <= live_a[MCSD_SW_RSTSRC];
      timeout_sel_o <= {live_a[MCSD_SW_TO_HI], live_a[MCSD_SW_TO_LO]};
    end
  end

  // Held in a flop beside the selection so both move at the capture edge only
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      timeout_sec_o <= MCSD_TO_SEC_0;
    end else if (state == MCSD_ST_SETTLE && settle_cnt >= SETTLE_CYC - 1) begin
      unique case ({live_a[MCSD_SW_TO_HI], live_a[MCSD_SW_TO_LO]})
        2'h0: timeout_sec_o <= MCSD_TO_SEC_0;
        2'h1: timeout_sec_o <= MCSD_TO_SEC_1;
        2'h2: timeout_sec_o <= MCSD_TO_SEC_2;
        2'h3: timeout_sec_o <= MCSD_TO_SEC_3;
      endcase
    end
  end

  // Seven-segment digits, segments g..a
  function automatic logic [6:0] mcsd_seg(input logic [3:0] d);
    logic [6:0] s;
    s = MCSD_SEG_BLANK;
    unique case (d)
      4'h0: s = 7'h3f;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5b;
      4'h3: s = 7'h4f;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6d;
      4'h6: s = 7'h7d;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h6f;
      default: s = MCSD_SEG_BLANK;
    endcase
    return s;
  endfunction : mcsd_seg

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      seg_tens_o <= MCSD_SEG_BLANK;
      seg_ones_o <= MCSD_SEG_BLANK;
    end else if (state == MCSD_ST_FAULT) begin
      seg_tens_o <= MCSD_SEG_ERR;
      seg_ones_o <= MCSD_SEG_BLANK;
    end else if (state == MCSD_ST_RUN) begin
      seg_tens_o <= mcsd_seg(4'(mode_num_o / 7'h0a));
      seg_ones_o <= mcsd_seg(4'(mode_num_o % 7'h0a));
    end
  end

  // Sticky status: set wins over write-one-to-clear
  assign events[MCSD_ST_MISMATCH] = mismatch_now && (state != MCSD_ST_FAULT) &&
                                    (state == MCSD_ST_RUN || mode_bad_now ||
                                     (state == MCSD_ST_SETTLE && settle_cnt >= SETTLE_CYC - 1));
  assign events[MCSD_ST_CHANGE] = change_now;
  assign events[MCSD_ST_MODE] = mode_bad_now;
  assign events[MCSD_ST_READY] = (state == MCSD_ST_SETTLE) && (settle_cnt >= SETTLE_CYC - 1) &&
                                 mode_ok && !mismatch_now;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      status <= '0;
    end else begin
      for (int i = 0; i < MCSD_ST_W; i++) begin
        if (events[i]) begin
          status[i] <= 1'b1;
        end else if (wr_en && paddr_i == MCSD_OFF_STATUS && pstrb_i[0] && pwdata_i[i]) begin
          status[i] <= 1'b0;
        end
      end
    end
  end

  // Fault cause kept separately so clearing status cannot drop the fault pin
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fault_hold <= '0;
    end else begin
      fault_hold <= fault_hold | {1'b0, events[MCSD_ST_MODE:0]};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fault_o <= 1'b0;
      safety_out_a_o <= 1'b0;
      safety_out_b_o <= 1'b0;
    end else begin
      fault_o <= (state == MCSD_ST_FAULT) || (|fault_hold);
      safety_out_a_o <= (state == MCSD_ST_RUN) && !mismatch_now && !change_now &&
                        safety_enable_i;
      safety_out_b_o <= (state == MCSD_ST_RUN) && !mismatch_now && !change_now &&
                        safety_enable_i;
    end
  end
  assign config_valid_o = (state == MCSD_ST_RUN);
  assign irq_o = |(status & mask);

  // APB slave, zero wait states
  assign pready_o = 1'b1;
  assign addr_ok = (paddr_i == MCSD_OFF_STATUS) || (paddr_i == MCSD_OFF_MASK) ||
                   (paddr_i == MCSD_OFF_CONFIG) || (paddr_i == MCSD_OFF_LIVE) ||
                   (paddr_i == MCSD_OFF_CTRL);
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mask <= MCSD_MASK_RST;
    end else if (wr_en && paddr_i == MCSD_OFF_MASK && pstrb_i[0]) begin
      mask <= pwdata_i[MCSD_ST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr_i)
        MCSD_OFF_STATUS: prdata_o <= {28'h0000000, status};
        MCSD_OFF_MASK: prdata_o <= {28'h0000000, mask};
        MCSD_OFF_CONFIG: prdata_o <= {17'h00000, mode_num_o, captured};
        MCSD_OFF_LIVE: prdata_o <= {16'h0000, live_b, live_a};
        MCSD_OFF_CTRL: prdata_o <= {29'h00000000, state};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  mismatch_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mismatch_now |=> !safety_out_a_o && !safety_out_b_o)
    else $error("safety output on with banks disagreeing");
  change_fault_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    change_now |=> state == MCSD_ST_FAULT ##1 fault_o)
    else $error("switch change did not latch a fault");
  fault_sticky_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_FAULT |=> state == MCSD_ST_FAULT [*3])
    else $error("fault state left without reset");
  mode_bad_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mode_bad_now |=> state == MCSD_ST_FAULT && status[MCSD_ST_MODE])
    else $error("illegal mode not flagged");
  fault_pin_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_FAULT |=> fault_o)
    else $error("fault pin low in fault state");
  no_fault_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(fault_o) |-> $past(state) == MCSD_ST_FAULT || $past(|fault_hold))
    else $error("fault pin raised without cause");
  decode_sensors_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_RUN |-> four_sensor_o == captured[MCSD_SW_SENSORS] &&
    restart_local_o == captured[MCSD_SW_RESTART])
    else $error("decoded setting differs from captured bank");
  decode_misc_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_RUN |-> extension_en_o == captured[MCSD_SW_EXT] &&
    mute_from_first_muting_sensor_o == captured[MCSD_SW_MUTSRC] &&
    reset_from_control_o == captured[MCSD_SW_RSTSRC])
    else $error("decoded source setting wrong");
  timeout_map_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    timeout_sel_o == 2'h2 |-> timeout_sec_o == MCSD_TO_SEC_2)
    else $error("timeout selection decoded wrong");
  display_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(state == MCSD_ST_RUN) |=> seg_ones_o != MCSD_SEG_BLANK)
    else $error("display blank after start-up");
  // Outputs must be low in the cycle after any cycle the block is not in run
  off_outside_run_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !config_valid_o |=> !safety_out_a_o && !safety_out_b_o)
    else $error("safety output on outside run state");
  fault_outputs_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fault_o |-> !safety_out_a_o && !safety_out_b_o)
    else $error("safety output on while fault pin high");
  decode_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_RUN |-> sequence_mode_o == captured[MCSD_SW_SEQ] &&
    timeout_sel_o == {captured[MCSD_SW_TO_HI], captured[MCSD_SW_TO_LO]})
    else $error("muting mode or timeout selection differs from capture");
  legal_run_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_RUN |-> !(captured[MCSD_SW_SENSORS] && !captured[MCSD_SW_SEQ]))
    else $error("run entered with a forbidden mode");
  change_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    change_now |=> status[MCSD_ST_CHANGE])
    else $error("switch change not flagged in status");
  banks_equal_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    safety_out_a_o |-> !$past(mismatch_now))
    else $error("safety output on after banks disagreed");
  c_run: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(safety_out_a_o));
  c_change: cover property (@(posedge clk_sys_i) disable iff (reset_i) change_now);
  c_mode: cover property (@(posedge clk_sys_i) disable iff (reset_i) mode_bad_now);
  c_irq: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(irq_o));
  c_start_fault: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    state == MCSD_ST_SETTLE ##1 state == MCSD_ST_FAULT);
endmodule : mcsd_top
`default_nettype wire

// [muting_config_switch_decoder_tb.sv]
// Purpose: self-checking bench for the configuration switch decoder
// Assumes: settle count shortened to 4 cycles, zero-wait register bus
// Notes: expected decode is rebuilt here from switch positions alone
`timescale 1ns/1ps
`default_nettype none
module muting_config_switch_decoder_tb;
  import mcsd_pkg::*;
  localparam int unsigned SETTLE = 4;
  logic clk_sys_i = 0, reset_i = 1, safety_enable_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, setting = 0, skew = 0, bank_a, bank_b;
  logic [31:0] pwdata = 0, prdata_o, rd, timeout_sec_o;
  logic pready_o, pslverr_o, irq_o, safety_out_a_o, safety_out_b_o, fault_o, err;
  logic config_valid_o, four_sensor_o, sequence_mode_o, extension_en_o, restart_local_o;
  logic mute_from_first_muting_sensor_o, reset_from_control_o;
  logic [1:0] timeout_sel_o;
  logic [6:0] mode_num_o, seg_tens_o, seg_ones_o;
  logic [6:0] seg7 [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic [31:0] tsec [4] = '{32'd20, 32'd120, 32'd600, 32'd360000};
  int bad_count = 0, n_tests = 0;
  integer seed = 32'hce86f66c;
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  mcsd_switch_model i_sw (.setting_i(setting), .skew_i(skew), .bank_a_o(bank_a), .bank_b_o(bank_b));
  mcsd_top #(.SETTLE_CYC(SETTLE)) i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .bank_a_i(bank_a), .bank_b_i(bank_b), .safety_enable_i(safety_enable_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hf), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .safety_out_a_o(safety_out_a_o), .safety_out_b_o(safety_out_b_o),
    .fault_o(fault_o), .config_valid_o(config_valid_o), .four_sensor_o(four_sensor_o),
    .sequence_mode_o(sequence_mode_o), .extension_en_o(extension_en_o),
    .restart_local_o(restart_local_o),
    .mute_from_first_muting_sensor_o(mute_from_first_muting_sensor_o),
    .reset_from_control_o(reset_from_control_o), .timeout_sel_o(timeout_sel_o),
    .timeout_sec_o(timeout_sec_o), .mode_num_o(mode_num_o), .seg_tens_o(seg_tens_o),
    .seg_ones_o(seg_ones_o));
  task test_done;
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // One bus transfer; the request is held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (pready_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      bad_count++;
      $display("[FAIL] %0t bus transfer hung", $time);
      test_done();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel <= 0;
    penable <= 0;
    // A write lands at the access edge; give it one edge before callers look
    if (wr) @(posedge clk_sys_i);
  endtask : apb
  // Waits for run or fault, or for fault alone when for_fault is set; a fixed margin lets the registered pins follow
  task wait_out(input logic for_fault);
    int k;
    k = 0;
    while (fault_o !== 1'b1 && (for_fault || config_valid_o !== 1'b1) && k < SETTLE + 40) begin
      @(posedge clk_sys_i);
      k++;
    end
    if (k >= SETTLE + 40) begin
      bad_count++;
      $display("[FAIL] %0t no start-up or fault", $time);
      test_done();
    end
    repeat (3) @(posedge clk_sys_i);
  endtask : wait_out
  task start(input logic [7:0] v, input logic [7:0] sk);
    @(posedge clk_sys_i);
    reset_i <= 1;
    setting <= v;
    skew <= sk;
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 0;
    wait_out(0);
  endtask : start
  task check_cfg(input logic [7:0] v, input logic [7:0] sk);
    logic bad;
    int m;
    bad = (sk != 0) || (v[0] && !v[1]);
    m = {v[0], v[1], v[2], v[3], !v[4], v[5]} + 1;
    chk(fault_o, bad, "fault pin");
    chk(config_valid_o, !bad, "run state");
    chk(safety_out_a_o, !bad, "safety a");
    chk(safety_out_b_o, !bad, "safety b");
    apb(0, MCSD_OFF_STATUS, 0);
    if (sk != 0) begin
      chk(rd[MCSD_ST_MISMATCH], 1, "mismatch flag");
    end else if (bad) begin
      chk(rd[MCSD_ST_MODE], 1, "mode flag");
    end else begin
      chk(four_sensor_o, v[0], "sensor count");
      chk(sequence_mode_o, v[1], "muting mode");
      chk(extension_en_o, v[2], "extension");
      chk(restart_local_o, v[3], "restart source");
      chk(mute_from_first_muting_sensor_o, v[4], "muting source");
      chk(reset_from_control_o, v[5], "reset source");
      chk(timeout_sel_o, {v[6], v[7]}, "timeout select");
      chk(timeout_sec_o, tsec[{v[6], v[7]}], "timeout seconds");
      chk(mode_num_o, m, "mode number");
      chk(seg_ones_o, seg7[m % 10], "ones digit");
      chk(seg_tens_o, seg7[m / 10], "tens digit");
      apb(0, MCSD_OFF_CONFIG, 0);
      chk(rd, {17'h0, m[6:0], v}, "captured config");
    end
    if (bad) begin
      chk(seg_tens_o, MCSD_SEG_ERR, "error digit");
      chk(seg_ones_o, MCSD_SEG_BLANK, "blank digit");
    end
  endtask : check_cfg
  initial begin
    logic [7:0] v;
    int i;
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h10 : 8'($random(seed));
      if (v[0] && !v[1])
        v[1] = 1;
      v[7:6] = i[1:0];
      start(v, 0);
      check_cfg(v, 0);
      $display("Decode test %0d done", i);
    end
    start(8'h13, 8'h04);
    check_cfg(8'h13, 8'h04);
    start(8'h01, 8'h00);
    check_cfg(8'h01, 8'h00);
    $display("Start-up fault tests done");
    start(8'h23, 0);
    apb(0, MCSD_OFF_LIVE, 0);
    chk(rd, 32'h0000_2323, "live banks");
    apb(0, MCSD_OFF_CTRL, 0);
    chk(rd, 32'h2, "state run");
    apb(1, MCSD_OFF_CONFIG, 32'h0);
    apb(0, MCSD_OFF_CONFIG, 0);
    chk(rd, 32'h0000_3423, "config read only");
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    apb(1, MCSD_OFF_MASK, 32'h8);
    chk(irq_o, 1, "ready irq");
    apb(0, MCSD_OFF_MASK, 0);
    chk(rd, 32'h8, "mask readback");
    apb(1, MCSD_OFF_MASK, 32'h0);
    chk(irq_o, 0, "masked irq");
    apb(1, MCSD_OFF_MASK, 32'h8);
    apb(1, MCSD_OFF_STATUS, 32'h8);
    chk(irq_o, 0, "cleared irq");
    safety_enable_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk(safety_out_a_o | safety_out_b_o, 0, "enable gating");
    safety_enable_i <= 1;
    repeat (2) @(posedge clk_sys_i);
    chk(safety_out_a_o & safety_out_b_o, 1, "enable restored");
    apb(1, MCSD_OFF_MASK, 32'h2);
    setting <= 8'h2b;
    wait_out(1);
    chk(fault_o, 1, "change fault");
    chk(safety_out_a_o | safety_out_b_o, 0, "change outputs off");
    chk(irq_o, 1, "change irq");
    apb(0, MCSD_OFF_STATUS, 0);
    chk(rd[MCSD_ST_CHANGE], 1, "change flag");
    $display("Register and change tests done");
    start(8'h37, 0);
    skew <= 8'h80;
    wait_out(1);
    chk(fault_o, 1, "run mismatch fault");
    chk(safety_out_a_o | safety_out_b_o, 0, "mismatch outputs off");
    apb(0, MCSD_OFF_CTRL, 0);
    chk(rd, 32'h4, "state fault");
    $display("Run mismatch test done");
    test_done();
  end
endmodule : muting_config_switch_decoder_tb
`default_nettype wire
